// file: verilog/console_bootstrap_loader.v
/*
  Console command interpreter and bootstrap loader. Consumes bytes from the
  selected character device, runs octal, binary and mass-storage loads, and
  exposes its state over an Avalon-MM slave. Assumes core_clk 125 MHz, rst_b
  async active low, byte and mass-storage inputs synchronous to core_clk.
*/
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
// Overview of operation
// RULE1 - After internal examine, octal number plus CR writes that register; status low 8 bits only.
// RULE2 - Deposit codes: 3 paging, 5 int enable, 6 detect, 7 enable mask, 10,12,15 cache/ecc.
// RULE3 - Operator must not deposit with codes 16 or 17.
// RULE4 - Asterisk prints current location; examine loads it, CR increments it.
// RULE5 - At-sign restarts interpreter, ends octal load, clears enable mask.
// RULE6 - Number then bank command selects one of four 64K banks.
// RULE7 - Device address then octal-load command switches input to that device.
// RULE8 - Octal load: no echo, legal commands still executed.
// RULE9 - Illegal command in octal load ends it, prints question mark or lamp.
// RULE10 - Descriptor decides procedure on load button or lone octal/binary load.
// RULE11 - Binary loader skips leader to exclamation, optional start number before.
// RULE12 - Block start address is two bytes, high first.
// RULE13 - Word count is two bytes, high first, data words only.
// RULE14 - Data words two bytes high first, stored at consecutive addresses.
// RULE15 - Checksum two bytes high first equals 16-bit sum of data.
// RULE16 - Checksum mismatch prints question mark or lamp, returns to interpreter.
// RULE17 - Zero action byte starts at start number; nonzero is a command.
// RULE18 - Line feed ignored inside header octal numbers.
// RULE19 - Loader uses no memory storage; start number left in level-0 counter.
// RULE20 - Mass load copies 1K words from 0 to memory 0, then starts at 0.
// RULE21 - Mass load error ends load, question mark or lamp, back to interpreter.
// RULE22 - Mass load only from lone load command or button with mass flag.
// RULE23 - Descriptor: bit15 extension, 14 restart, 13 mass, 12 octal, 11-0 address.
// RULE24 - Extension set: jump to microprogram address in bits 0-11.
// RULE25 - Restart set, extension clear: jump to memory address four times bits 0-13.
// RULE26 - Mass set, upper clear: mass load from device in bits 0-10.
// RULE27 - Octal bit picks octal or binary load; lone octal command forces octal.
// RULE28 - Decode priority: extension, restart, mass, format.
`timescale 1ns/1ps
`default_nettype none
`include "console_loader_defines.vh"

module console_bootstrap_loader #(
  parameter CONSOLE_PRESENT = 1
) (
  input wire core_clk, // System clock
  input wire rst_b, // Async reset, active low
  input wire [5:0] avsAddress, // Word-aligned byte address bits 7:2
  input wire avsRead, // Read request
  input wire avsWrite, // Write request
  input wire [31:0] avsWritedata, // Write data
  input wire [3:0] avsByteenable, // Byte lanes
  output reg [31:0] avsReaddata, // Read data
  output reg avsWaitrequest, // Stall
  input wire [15:0] autoLoadDescriptor, // Load descriptor switches
  input wire loadButton, // Load button pulse
  input wire rxValid, // Byte from selected device
  input wire [7:0] rxData, // Byte value
  output reg rxDevice, // Nonzero-device select: 1 while input is a load device
  output reg [10:0] rxDevAddr, // Lowest address of input device
  output reg txValid, // Console character strobe
  output reg [7:0] txData, // Console character
  output reg [15:0] printValue, // Value to print in octal
  output reg printStrobe, // Print octal value pulse
  output reg memWrite, // Memory store pulse
  output reg [17:0] memAddr, // Memory address with bank
  output reg [15:0] memData, // Memory store data
  output reg massStart, // Mass load request pulse
  input wire massWordValid, // Mass word arrived
  input wire [15:0] massWord, // Mass word value
  input wire massError, // Mass load error pulse
  output reg startCpu, // Start processor pulse
  output reg [15:0] startAddr, // Start address
  output reg microJump, // Microprogram jump pulse
  output reg [11:0] microAddr, // Microprogram address
  output reg attentionLamp, // Lamp when no console
  output reg cacheClear // Cache clear pulse
);
  localparam S_CMD = 4'h0, S_LEAD = 4'h1, S_NUMB = 4'h2, S_NUMC = 4'h3, S_HDR = 4'h4;
  localparam S_DATA = 4'h5, S_CSUM = 4'h6, S_ACT = 4'h7, S_MASS = 4'h8;

  reg [3:0] st_q;
  reg [15:0] num_q;
  reg numHas_q;
  reg [1:0] prefix_q; // 0 none, 1 internal, 2 internal-examined, 3 memory-examined
  reg [3:0] icode_q;
  reg octLoad_q;
  reg [15:0] clc_q;
  reg [1:0] bank_q;
  reg [15:0] pie_q, pid_q, iie_q, pcr_q, cache_inhibit_limits_q, ecc_q, psw_q;
  reg [15:0] pc0_q;
  reg [15:0] addr_q, count_q, sum_q, word_q;
  reg hiByte_q;
  reg [1:0] hdrIdx_q;
  reg [7:0] errCount_q;

  function isOctal;
    input [7:0] c;
    isOctal = (c >= 8'h30) && (c <= 8'h37);
  endfunction

  wire [15:0] numNext = {num_q[12:0], rxData[2:0]};
  wire [15:0] assembled = {word_q[7:0], rxData};

  task failLoad;
    begin
      st_q <= S_CMD; // RULE9 RULE16 RULE21
      octLoad_q <= 1'b0;
      rxDevice <= 1'b0;
      if (CONSOLE_PRESENT != 0) begin
        txValid <= 1'b1;
        txData <= `CH_QUEST;
      end else begin
        attentionLamp <= 1'b1;
      end
      errCount_q <= errCount_q + 8'h01;
    end
  endtask

  task launchLoad;
    input forceOct;
    input explicitDev;
    begin
      num_q <= 16'h0000;
      numHas_q <= 1'b0;
      if (explicitDev) begin
        rxDevAddr <= num_q[10:0]; // RULE7
        rxDevice <= 1'b1;
        if (forceOct) octLoad_q <= 1'b1; // RULE7
        else st_q <= S_LEAD;
      end else if (autoLoadDescriptor[`LD_EXT]) begin // RULE10 RULE23 RULE28
        microJump <= 1'b1; // RULE24
        microAddr <= autoLoadDescriptor[11:0];
      end else if (autoLoadDescriptor[`LD_RJMP]) begin
        startCpu <= 1'b1; // RULE25
        startAddr <= {autoLoadDescriptor[13:0], 2'b00};
      end else if (autoLoadDescriptor[`LD_MASS]) begin // Lone $ overrides format only
        massStart <= 1'b1; // RULE22 RULE26
        rxDevAddr <= autoLoadDescriptor[10:0];
        addr_q <= 16'h0000; // RULE20
        count_q <= `MASS_WORDS;
        st_q <= S_MASS;
      end else begin
        rxDevAddr <= autoLoadDescriptor[10:0];
        rxDevice <= 1'b1;
        if (forceOct || autoLoadDescriptor[`LD_OCT]) octLoad_q <= 1'b1; // RULE27
        else st_q <= S_LEAD;
      end
    end
  endtask

  task command;
    input [7:0] c;
    begin
      if (!octLoad_q) begin
        txValid <= 1'b1; // RULE8
        txData <= c;
      end
      if (isOctal(c)) begin
        num_q <= numNext;
        numHas_q <= 1'b1;
      end else begin
        num_q <= 16'h0000;
        numHas_q <= 1'b0;
        case (c)
          `CH_AT: begin
            pie_q <= 16'h0000; // RULE5
            octLoad_q <= 1'b0;
            rxDevice <= 1'b0;
            prefix_q <= 2'd0;
          end
          `CH_INT: prefix_q <= 2'd1;
          `CH_SLASH: begin
            if (prefix_q == 2'd1) begin
              icode_q <= num_q[3:0];
              prefix_q <= 2'd2;
            end else begin
              clc_q <= num_q; // RULE4
              prefix_q <= 2'd3;
            end
          end
          `CH_CR: begin
            if (prefix_q == 2'd2 && numHas_q) begin // RULE1 RULE2
              case (icode_q)
                `IC_STATUS: psw_q[7:0] <= num_q[7:0];
                `IC_PAGING: pcr_q <= num_q;
                `IC_IIE: iie_q <= num_q;
                `IC_PID: pid_q <= num_q;
                `IC_PIE: pie_q <= num_q;
                `IC_CACHE_CLEAR: cacheClear <= 1'b1;
                `IC_CACHE_INHIBIT_LIMITS: cache_inhibit_limits_q <= num_q;
                `IC_ECC: ecc_q <= num_q;
                default: ; // RULE3
              endcase
            end else if (prefix_q == 2'd3) begin
              if (numHas_q) begin
                memWrite <= 1'b1;
                memAddr <= {bank_q, clc_q};
                memData <= num_q;
              end
              clc_q <= clc_q + 16'h0001; // RULE4
            end
          end
          `CH_STAR: begin
            printValue <= clc_q; // RULE4
            printStrobe <= 1'b1;
          end
          `CH_BANK: bank_q <= num_q[1:0]; // RULE6
          `CH_DOLLAR: launchLoad(1'b1, numHas_q);
          `CH_AMP: launchLoad(1'b0, numHas_q);
          `CH_BANG: begin
            octLoad_q <= 1'b0;
            rxDevice <= 1'b0;
            startCpu <= 1'b1;
            startAddr <= numHas_q ? num_q : pc0_q;
          end
          `CH_LF, `CH_SPACE: ;
          default: begin
            if (octLoad_q) failLoad; // RULE9
            else begin
              txValid <= 1'b1;
              txData <= `CH_QUEST;
            end
          end
        endcase
      end
    end
  endtask

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= S_CMD;
      num_q <= 16'h0000;
      numHas_q <= 1'b0;
      prefix_q <= 2'd0;
      icode_q <= 4'h0;
      octLoad_q <= 1'b0;
      clc_q <= 16'h0000;
      bank_q <= 2'b00;
      pie_q <= 16'h0000;
      pid_q <= 16'h0000;
      iie_q <= 16'h0000;
      pcr_q <= 16'h0000;
      cache_inhibit_limits_q <= 16'h0000;
      ecc_q <= 16'h0000;
      psw_q <= 16'h0000;
      pc0_q <= 16'h0000;
      addr_q <= 16'h0000;
      count_q <= 16'h0000;
      sum_q <= 16'h0000;
      word_q <= 16'h0000;
      hiByte_q <= 1'b1;
      hdrIdx_q <= 2'd0;
      errCount_q <= 8'h00;
      rxDevice <= 1'b0;
      rxDevAddr <= 11'h000;
      txValid <= 1'b0;
      txData <= 8'h00;
      printValue <= 16'h0000;
      printStrobe <= 1'b0;
      memWrite <= 1'b0;
      memAddr <= 18'h00000;
      memData <= 16'h0000;
      massStart <= 1'b0;
      startCpu <= 1'b0;
      startAddr <= 16'h0000;
      microJump <= 1'b0;
      microAddr <= 12'h000;
      attentionLamp <= 1'b0;
      cacheClear <= 1'b0;
    end else begin
      txValid <= 1'b0;
      printStrobe <= 1'b0;
      memWrite <= 1'b0;
      massStart <= 1'b0;
      startCpu <= 1'b0;
      microJump <= 1'b0;
      cacheClear <= 1'b0;
      if (st_q == S_CMD && loadButton) begin
        launchLoad(1'b0, 1'b0); // RULE10 RULE22
      end else if (st_q == S_MASS) begin
        if (massError) failLoad; // RULE21
        else if (massWordValid) begin
          memWrite <= 1'b1; // RULE20
          memAddr <= {2'b00, addr_q};
          memData <= massWord;
          addr_q <= addr_q + 16'h0001;
          count_q <= count_q - 16'h0001;
          if (count_q == 16'h0001) begin
            st_q <= S_CMD;
            startCpu <= 1'b1;
            startAddr <= 16'h0000;
          end
        end
      end else if (rxValid) begin
        case (st_q)
          S_CMD: command(rxData);
          S_LEAD: begin // RULE11
            num_q <= 16'h0000;
            if (rxData == `CH_BANG) begin
              st_q <= S_HDR;
              pc0_q <= 16'h0000;
            end else if (isOctal(rxData)) begin
              num_q <= {13'h0000, rxData[2:0]};
              st_q <= S_NUMB;
            end
          end
          S_NUMB: begin
            if (isOctal(rxData)) num_q <= numNext;
            else if (rxData == `CH_LF) ; // RULE18
            else begin
              pc0_q <= num_q; // RULE19
              num_q <= 16'h0000;
              st_q <= (rxData == `CH_BANG) ? S_HDR : S_NUMC;
            end
          end
          S_NUMC: begin
            if (rxData == `CH_BANG) st_q <= S_HDR; // RULE11
          end
          S_HDR, S_DATA, S_CSUM: begin
            word_q <= {8'h00, rxData};
            hiByte_q <= ~hiByte_q;
            if (!hiByte_q) begin
              if (st_q == S_HDR) begin
                if (hdrIdx_q == 2'd0) addr_q <= assembled; // RULE12
                else count_q <= assembled; // RULE13
                hdrIdx_q <= hdrIdx_q + 2'd1;
                sum_q <= 16'h0000;
                if (hdrIdx_q == 2'd1) begin
                  hdrIdx_q <= 2'd0;
                  st_q <= (assembled == 16'h0000) ? S_CSUM : S_DATA;
                end
              end else if (st_q == S_DATA) begin
                memWrite <= 1'b1; // RULE14
                memAddr <= {bank_q, addr_q};
                memData <= assembled;
                sum_q <= sum_q + assembled; // RULE15
                addr_q <= addr_q + 16'h0001;
                count_q <= count_q - 16'h0001;
                if (count_q == 16'h0001) st_q <= S_CSUM;
              end else begin
                if (assembled != sum_q) failLoad; // RULE16
                else st_q <= S_ACT;
              end
            end
          end
          S_ACT: begin
            st_q <= S_CMD;
            rxDevice <= 1'b0;
            if (rxData == 8'h00) begin
              startCpu <= 1'b1; // RULE17
              startAddr <= pc0_q;
            end else begin
              command(rxData);
            end
          end
          default: st_q <= S_CMD;
        endcase
      end
    end
  end

  // Bus: one wait cycle so read data come from a flop
  reg [31:0] rd_d;
  always @* begin
    case ({avsAddress, 2'b00})
      {4'h0, `REG_DESC}: rd_d = {16'h0000, autoLoadDescriptor};
      {4'h0, `REG_STATUS}: rd_d = {16'h0000, errCount_q, 2'b00, numHas_q, octLoad_q, st_q};
      {4'h0, `REG_CLC}: rd_d = {14'h0000, bank_q, clc_q};
      {4'h0, `REG_PIE}: rd_d = {16'h0000, pie_q};
      `REG_PCR: rd_d = {16'h0000, pcr_q};
      `REG_IIE: rd_d = {16'h0000, iie_q};
      `REG_PID: rd_d = {16'h0000, pid_q};
      `REG_CACHE_INHIBIT_LIMITS: rd_d = {16'h0000, cache_inhibit_limits_q};
      `REG_ECC: rd_d = {16'h0000, ecc_q};
      `REG_START: rd_d = {16'h0000, pc0_q};
      `REG_DEVADR: rd_d = {21'h000000, rxDevAddr};
      `REG_PSW: rd_d = {16'h0000, psw_q};
      default: rd_d = 32'h00000000;
    endcase
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      avsWaitrequest <= 1'b1;
      avsReaddata <= 32'h00000000;
    end else begin
      avsWaitrequest <= ~((avsRead | avsWrite) & avsWaitrequest);
      if (avsRead) avsReaddata <= rd_d;
    end
  end
endmodule // console_bootstrap_loader
`default_nettype wire

// file: verilog/console_loader_defines.vh
/*
  Constants for the console command and bootstrap loader: characters, internal
  deposit codes, load descriptor fields, Avalon register offsets.
  Assumes inclusion by bare name from the loader module.
*/
`ifndef CONSOLE_LOADER_DEFINES_VH
`define CONSOLE_LOADER_DEFINES_VH

`define CH_AT 8'h40
`define CH_DOLLAR 8'h24
`define CH_AMP 8'h26
`define CH_BANG 8'h21
`define CH_SLASH 8'h2f
`define CH_CR 8'h0d
`define CH_LF 8'h0a
`define CH_SPACE 8'h20
`define CH_STAR 8'h2a
`define CH_QUEST 8'h3f
`define CH_BANK 8'h42
`define CH_INT 8'h49

`define IC_STATUS 4'h1
`define IC_PAGING 4'h3
`define IC_IIE 4'h5
`define IC_PID 4'h6
`define IC_PIE 4'h7
`define IC_CACHE_CLEAR 4'h8
`define IC_UNUSED 4'h9
`define IC_CACHE_INHIBIT_LIMITS 4'ha
`define IC_ECC 4'hd

`define LD_EXT 15
`define LD_RJMP 14
`define LD_MASS 13
`define LD_OCT 12

`define MASS_WORDS 16'h0400

`define REG_DESC 4'h0
`define REG_STATUS 4'h4
`define REG_CLC 4'h8
`define REG_PIE 4'hc
`define REG_PCR 8'h10
`define REG_IIE 8'h14
`define REG_PID 8'h18
`define REG_CACHE_INHIBIT_LIMITS 8'h1c
`define REG_ECC 8'h20
`define REG_CTRL 8'h24
`define REG_START 8'h28
`define REG_BANK 8'h2c
`define REG_DEVADR 8'h30
`define REG_PSW 8'h34

`endif

// file: verif/console_bootstrap_loader_properties.sv
/* Port-level assertions for the console loader.
   Assumes one clock domain and binding onto the loader's top module. */
`timescale 1ns/1ps
`default_nettype none
module loader_checker #(
  parameter CONSOLE_PRESENT = 1
) (
  input wire core_clk, // Clock
  input wire rst_b, // Reset, low
  input wire [5:0] avsAddress, // Word index
  input wire avsRead, // Read
  input wire avsWrite, // Write
  input wire [31:0] avsReaddata, // Read data
  input wire avsWaitrequest, // Stall
  input wire [15:0] autoLoadDescriptor, // Switches
  input wire loadButton, // Load
  input wire rxValid, // Byte strobe
  input wire [7:0] rxData, // Byte
  input wire rxDevice, // Device input
  input wire txValid, // Char strobe
  input wire printStrobe, // Octal print
  input wire massStart, // Mass request
  input wire startCpu, // Start
  input wire [15:0] startAddr, // Start address
  input wire microJump, // Micro jump
  input wire [11:0] microAddr // Micro address
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_bus_answer: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("bus answer late");
  a_desc_read: assert property (avsRead && avsAddress == 6'h00 && avsWaitrequest
    |=> avsReaddata[15:0] == $past(autoLoadDescriptor)) else $error("descriptor read wrong");
  a_no_echo: assert property (rxValid && rxDevice && rxData >= 8'h30 && rxData <= 8'h37
    |=> !txValid) else $error("device digit echoed");
  a_star_print: assert property (rxValid && rxData == 8'h2a && !rxDevice
    |-> ##[1:3] printStrobe) else $error("location not printed");
  a_ext_jump: assert property (loadButton && autoLoadDescriptor[15]
    |-> ##[1:4] (microJump && microAddr == autoLoadDescriptor[11:0])) else $error("no micro jump");
  a_restart_jump: assert property (loadButton && autoLoadDescriptor[15:14] == 2'b01
    |-> ##[1:4] (startCpu && startAddr == {autoLoadDescriptor[13:0], 2'b00}))
    else $error("no restart jump");
  a_mass_launch: assert property (loadButton && autoLoadDescriptor[15:13] == 3'b001
    |-> ##[1:4] massStart) else $error("mass load not launched");
  a_mass_origin: assert property (massStart |-> autoLoadDescriptor[15:13] == 3'b001)
    else $error("mass load without flag");
endmodule // loader_checker
bind console_bootstrap_loader loader_checker #(.CONSOLE_PRESENT(CONSOLE_PRESENT)) chk_u (
  .core_clk(core_clk), .rst_b(rst_b), .avsAddress(avsAddress), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
  .autoLoadDescriptor(autoLoadDescriptor), .loadButton(loadButton), .rxValid(rxValid),
  .rxData(rxData), .rxDevice(rxDevice), .txValid(txValid), .printStrobe(printStrobe),
  .massStart(massStart), .startCpu(startCpu), .startAddr(startAddr),
  .microJump(microJump), .microAddr(microAddr)
);
`default_nettype wire

// file: verif/mass_store_model.sv
/* Mass-storage controller model: streams words from storage address 0.
   Assumes massStart is a one-cycle request on core_clk. */
`timescale 1ns/1ps
`default_nettype none
module mass_store_model (
  input wire logic core_clk, // Clock
  input wire logic rst_b, // Reset, low
  input wire logic massStart, // Request
  input wire logic slow, // Word every 4th cycle
  input wire logic [10:0] failAt, // Faulting word, 0 none
  output logic massWordValid, // Word strobe
  output logic [15:0] massWord, // Word
  output logic massError // Fault pulse
);
  int idx;
  int gap;
  logic busy;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      gap <= 0;
      massWordValid <= 1'b0;
      massWord <= 16'h0000;
      massError <= 1'b0;
    end else begin
      massWordValid <= 1'b0;
      massError <= 1'b0;
      massWord <= ~massWord; // Stale word never looks valid
      if (massStart) begin
        busy <= 1'b1;
        idx <= 0;
      end else if (busy && gap > 0) begin
        gap <= gap - 1;
      end else if (busy && failAt != 0 && idx == failAt) begin
        massError <= 1'b1;
        busy <= 1'b0;
      end else if (busy) begin
        gap <= slow ? 3 : 0;
        massWordValid <= 1'b1;
        massWord <= idx[15:0] ^ 16'h5a5a;
        idx <= idx + 1;
        busy <= idx != 1023;
      end
    end
  end
endmodule // mass_store_model
`default_nettype wire

// file: verif/tb_console_bootstrap_loader.sv
/* Self-checking bench for the console loader: bus, console bytes, loads.
   Assumes the loader, its checker and the mass-storage model compile first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, s); end end
module tb_console_bootstrap_loader;
  logic core_clk = 1'b0, rst_b = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, loadButton = 1'b0;
  logic rxValid = 1'b0, slow = 1'b0;
  logic [5:0] avsAddress = 6'h00;
  logic [31:0] avsWritedata = 32'h0, avsReaddata, r;
  logic [15:0] autoLoadDescriptor = 16'h0, printValue, memData, massWord, startAddr, w;
  logic [7:0] rxData = 8'h00, txData, lastTx;
  logic [10:0] failAt = 11'h0, rxDevAddr;
  logic [17:0] memAddr;
  logic [11:0] microAddr;
  logic avsWaitrequest, rxDevice, txValid, printStrobe, memWrite, massStart, massWordValid;
  logic massError, startCpu, microJump, attentionLamp, cacheClear;
  logic [33:0] memQ[$], expQ[$];
  int n_errors = 0, n_compared = 0, seed = 95246, k;
  int nTx = 0, nStart = 0, nJump = 0, nPrint = 0, nClr = 0;
  int codes[7] = '{1, 3, 5, 6, 7, 10, 13}; // Codes 16 and 17 never sent
  logic [5:0] regs[7] = '{6'h0d, 6'h04, 6'h05, 6'h06, 6'h03, 6'h07, 6'h08};
  logic [15:0] descs[4] = '{16'hf000, 16'h8000, 16'h4000, 16'h7000};
  always #4 core_clk = ~core_clk;
  console_bootstrap_loader dut_u (.core_clk(core_clk), .rst_b(rst_b), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(4'hf),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .autoLoadDescriptor(autoLoadDescriptor), .loadButton(loadButton), .rxValid(rxValid),
    .rxData(rxData), .rxDevice(rxDevice), .rxDevAddr(rxDevAddr), .txValid(txValid),
    .txData(txData), .printValue(printValue), .printStrobe(printStrobe), .memWrite(memWrite),
    .memAddr(memAddr), .memData(memData), .massStart(massStart), .massWordValid(massWordValid),
    .massWord(massWord), .massError(massError), .startCpu(startCpu), .startAddr(startAddr),
    .microJump(microJump), .microAddr(microAddr), .attentionLamp(attentionLamp),
    .cacheClear(cacheClear));
  mass_store_model mass_u (.core_clk(core_clk), .rst_b(rst_b), .massStart(massStart),
    .slow(slow), .failAt(failAt), .massWordValid(massWordValid), .massWord(massWord),
    .massError(massError));
  always @(posedge core_clk) begin
    if (memWrite) memQ.push_back({memAddr, memData});
    if (txValid) lastTx = txData;
    nTx += txValid;
    nStart += startCpu;
    nJump += microJump;
    nPrint += printStrobe;
    nClr += cacheClear;
  end
  task report_and_stop;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic waitFor(ref int c, input int t);
    for (int i = 0; i < 5000 && c < t; i++) @(posedge core_clk);
    if (c < t) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  task automatic avAcc(input logic wr, input logic [5:0] a);
    int i;
    @(posedge core_clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWritedata <= 32'hffffffff;
    i = 0;
    do begin @(posedge core_clk); i++; end while (avsWaitrequest !== 1'b0 && i < 50);
    r = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    if (i >= 50) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  task sendB(input logic [7:0] b);
    @(posedge core_clk);
    rxValid <= 1'b1;
    rxData <= b;
    @(posedge core_clk);
    rxValid <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task sendS(input string s);
    for (int i = 0; i < s.len(); i++) sendB(s[i]);
  endtask
  task press;
    @(posedge core_clk);
    loadButton <= 1'b1;
    @(posedge core_clk);
    loadButton <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
  task cmpMem;
    logic [33:0] expW, seenW;
    `CHK("store count", expQ.size(), memQ.size())
    while (expQ.size() > 0 && memQ.size() > 0) begin
      expW = expQ.pop_front();
      seenW = memQ.pop_front();
      `CHK("store", expW, seenW)
    end
    expQ.delete();
    memQ.delete();
  endtask
  task automatic binLoad(input int n, input bit bad, input logic [7:0] act);
    logic [15:0] base, sum;
    base = 16'($random(seed));
    sum = 16'h0000;
    sendS("&xy1\n2 !");
    sendB(base[15:8]); sendB(base[7:0]);
    sendB(8'h00); sendB(n[7:0]);
    for (int i = 0; i < n; i++) begin
      w = 16'($random(seed));
      sum += w;
      expQ.push_back({2'b00, base + i[15:0], w});
      sendB(w[15:8]); sendB(w[7:0]);
    end
    if (bad) sum = {sum[15:8] + 8'h01, 8'h00};
    sendB(sum[15:8]); sendB(sum[7:0]);
    if (!bad) sendB(act);
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    autoLoadDescriptor <= 16'($random(seed));
    avAcc(1'b1, 6'h00);
    avAcc(1'b0, 6'h00);
    `CHK("descriptor", autoLoadDescriptor, r[15:0])
    avAcc(1'b0, 6'h0f);
    `CHK("unmapped", 32'h0, r)
    foreach (codes[i]) begin
      w = 16'($random(seed));
      sendS($sformatf("I%0o/%0o\r", codes[i], w));
      avAcc(1'b0, regs[i]);
      `CHK("internal", (codes[i] == 1) ? {8'h00, w[7:0]} : w, r[15:0])
    end
    sendS("I10/0\r");
    `CHK("cache clears", 1, nClr)
    sendS("@");
    avAcc(1'b0, 6'h03);
    `CHK("mask", 16'h0, r[15:0])
    sendS("300$");
    `CHK("device", 11'o300, rxDevice ? rxDevAddr : 11'h0)
    k = nTx;
    sendS("17");
    `CHK("echoes", k, nTx)
    sendS("Z");
    `CHK("illegal", 9'h03f, {rxDevice, lastTx})
    `CHK("lamp", 1'b0, attentionLamp)
    sendS("300$@");
    `CHK("break", 1'b0, rxDevice)
    autoLoadDescriptor <= 16'h00c0; // Binary from 300
    binLoad(3, 1'b0, 8'h00);
    waitFor(nStart, 1);
    `CHK("start", 16'o12, startAddr)
    cmpMem();
    avAcc(1'b0, 6'h0a);
    `CHK("level0 counter", 16'o12, r[15:0])
    k = nTx;
    binLoad(1, 1'b1, 8'h00);
    waitFor(nTx, k + 1);
    `CHK("checksum", 9'h13f, {nStart == 1, lastTx})
    cmpMem();
    k = nPrint;
    binLoad(0, 1'b0, 8'h2a);
    waitFor(nPrint, k + 1);
    foreach (descs[i]) begin
      w = 16'($random(seed)) & 16'h0fff | descs[i];
      autoLoadDescriptor <= w;
      press();
      if (w[15]) `CHK("micro", w[11:0], microAddr)
      else `CHK("restart", {w[13:0], 2'b00}, startAddr)
    end
    autoLoadDescriptor <= 16'h8123;
    sendS("&");
    `CHK("lone load", 12'h123, microAddr)
    `CHK("jumps", 3, nJump)
    autoLoadDescriptor <= 16'h2160;
    k = nStart;
    press();
    for (int i = 0; i < 1024; i++) expQ.push_back({2'b00, i[15:0], i[15:0] ^ 16'h5a5a});
    waitFor(nStart, k + 1);
    `CHK("mass start", 16'h0000, startAddr)
    cmpMem();
    slow <= 1'b1;
    failAt <= 11'd5;
    k = nTx;
    press();
    waitFor(nTx, k + 1);
    `CHK("mass fault", 8'h3f, lastTx)
    memQ.delete();
    sendS("2B5/123\r\r*");
    expQ.push_back({18'h20005, 16'o123});
    cmpMem();
    `CHK("location", 16'h0007, printValue)
    avAcc(1'b0, 6'h02);
    `CHK("bank", 18'h20007, r[17:0])
    report_and_stop();
  end
endmodule // tb_console_bootstrap_loader
`default_nettype wire
